/* exc_defs.svh */
// Purpose: Named constants for the exception priority and vector unit
// Assumes: Included by bare name
// Notes:   Offsets are byte addresses on the APB register bus
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH
// Register byte offsets
`define OFS_MASK      8'h00
`define OFS_PRIO      8'h04
`define OFS_PINCTL    8'h08
`define OFS_LOCAL     8'h0C
`define OFS_STATE     8'h10
`define OFS_EVT_STAT  8'h14
`define OFS_EVT_EN    8'h18
`define OFS_EVT_CLR   8'h1C
// Mask register bits, same places as in the condition code register
`define BIT_XMASK     6
`define BIT_IMASK     4
`define MASK_RESET    8'h50
// Pin control bits
`define BIT_EDGE      7
`define BIT_PIN_EN    6
`define PINCTL_RESET  8'h40
`define PINCTL_WMASK  8'hC0
// Local enable bits
`define BIT_PAOV_EN   0
`define BIT_PAEDGE_EN 1
`define BIT_SSDONE_EN 2
`define BIT_TXE_EN    3
`define BIT_TXC_EN    4
`define BIT_RXF_EN    5
`define BIT_IDLE_EN   6
`define BIT_MODU_EN   7
`define BIT_PB_EN     8
`define BIT_CM_EN     9
`define BIT_FCM_EN    10
`define LOCAL_W       11
// Fixed vectors
`define VEC_RESET     16'hFFFE
`define VEC_CLKMON    16'hFFFC
`define VEC_WDOG      16'hFFFA
`define VEC_TRAP      16'hFFF8
`define VEC_SWTRAP    16'hFFF6
`define VEC_NMI_PIN   16'hFFF4
`define VEC_HI_BYTE   8'hFF
// Maskable slots: vector low byte = 80 + 2 * slot
`define NSLOT         58
`define SLOT_MAX      6'h39
`define SLOT_PIN      6'h39
`define SLOT_PAOV     6'h2E
`define SLOT_PAEDGE   6'h2D
`define SLOT_SSDONE   6'h2C
`define SLOT_ASYNC    6'h2B
`define SLOT_MODU     6'h26
`define SLOT_PB       6'h25
`define PRIO_RESET    8'hF2
// Elevation byte fields
`define BIT_ELEV_PAGE 7
`define BIT_ELEV_ODD  0
`define ELEV_SLOT_HI  6
`define ELEV_SLOT_LO  1
// Event status bits
`define EVT_SERVICED  0
`define EVT_REFUSED   1
`define EVT_NMI       2
`define EVT_W         3
`endif

/* exc_pkg.sv */
// Purpose: Types for the exception priority and vector unit
// Assumes: Nothing
// Notes:   Constants live in exc_defs.svh
package exc_pkg;
  typedef logic [5:0]  slot_t;
  typedef logic [15:0] vec_t;
  // One-hot winner class among the fixed sources and the maskable group
  typedef enum logic [6:0] {
    WIN_NONE   = 7'h00,
    WIN_RESET  = 7'h01,
    WIN_CLKMON = 7'h02,
    WIN_WDOG   = 7'h04,
    WIN_TRAP   = 7'h08,
    WIN_SWTRAP = 7'h10,
    WIN_NMI    = 7'h20,
    WIN_MASK   = 7'h40
  } win_e;
endpackage

/* exception_priority_vectoring.sv */
// Purpose: Arbitrates resets and interrupts and delivers one 16-bit vector
// Assumes: Core-clock sources are synchronous; pins arrive asynchronously
// Notes:   APB slave, zero wait states, read word loads in the setup cycle
`timescale 1ns/1ps
`include "exc_defs.svh"

module exception_priority_vectoring (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  por_request,
  input  wire logic                  clock_monitor_fail,
  input  wire logic                  watchdog_reset,
  input  wire logic                  illegal_opcode_trap,
  input  wire logic                  software_trap_instruction,
  input  wire logic                  nonmaskable_pin_request_n,
  input  wire logic                  maskable_pin_n,
  input  wire logic [`NSLOT-1:0]     periph_request,
  input  wire logic                  pulse_acc_overflow_flag,
  input  wire logic                  pulse_acc_edge_flag,
  input  wire logic                  sync_serial_done_flag,
  input  wire logic [3:0]            async_serial_flags,
  input  wire logic                  modulus_underflow_flag,
  input  wire logic                  second_pulse_acc_overflow_flag,
  input  wire logic                  service_ack,
  output logic                       exception_request,
  output logic                       exception_nonmaskable,
  output logic      [15:0]           exception_vector,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  // Software copies of the core's mask bits and the control bytes;
  // the mask register resets with both mask bits set, so no
  // maskable source can win before software has set up its handlers
  logic [7:0]            mask_r;
  logic [7:0]            prio_r;
  logic [7:0]            pinctl_r;
  logic [`LOCAL_W-1:0]   local_r;
  logic [`EVT_W-1:0]     evt_stat_r;
  logic [`EVT_W-1:0]     evt_en_r;
  logic                  req_r;
  logic                  nmi_r;
  logic [15:0]           vec_r;
  logic [2:0]            pin_sync_r;
  logic [2:0]            nmi_sync_r;
  logic                  pin_level_r;
  logic                  nmi_level_r;
  logic                  edge_latch_r;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  // Writes land at the access edge; reads sample one cycle earlier,
  // in the setup cycle, so the word already stands when pready is seen
  wire        wr_acc    = psel & penable & pwrite;
  wire        rd_setup  = psel & ~penable & ~pwrite;
  wire        hit_mask  = (paddr == `OFS_MASK);
  wire        hit_prio  = (paddr == `OFS_PRIO);
  wire        hit_pin   = (paddr == `OFS_PINCTL);
  wire        hit_local = (paddr == `OFS_LOCAL);
  wire        hit_state = (paddr == `OFS_STATE);
  wire        hit_stat  = (paddr == `OFS_EVT_STAT);
  wire        hit_en    = (paddr == `OFS_EVT_EN);
  wire        hit_clr   = (paddr == `OFS_EVT_CLR);
  wire        mapped    = hit_mask | hit_prio | hit_pin | hit_local |
                          hit_state | hit_stat | hit_en | hit_clr;
  wire        i_mask    = mask_r[`BIT_IMASK];
  wire        x_mask    = mask_r[`BIT_XMASK];
  // Elevation write only lands while interrupts are inhibited
  wire        prio_take = wr_acc & hit_prio & i_mask;
  wire        prio_refd = wr_acc & hit_prio & ~i_mask;

  // Zero wait states; unmapped addresses answer with an error.
  // Every register answers in one access cycle, so no stall logic;
  // a refused write still completes cleanly on the bus, and only the
  // event bit tells software that it was dropped
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree.
  // A glitch shorter than a clock never reaches the arbiter, and reset
  // loads the idle high level, so no false fall follows reset; only
  // stages two and three are read, never the metastable first stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_r  <= 3'h7;
      nmi_sync_r  <= 3'h7;
      pin_level_r <= 1'b1;
      nmi_level_r <= 1'b1;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], maskable_pin_n};
      nmi_sync_r <= {nmi_sync_r[1:0], nonmaskable_pin_request_n};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_level_r <= pin_sync_r[2];
      if (nmi_sync_r[1] == nmi_sync_r[2])
        nmi_level_r <= nmi_sync_r[2];
    end
  end

  // Falling edge of the filtered pin level
  // Seen for exactly one cycle, as the filtered level drops
  wire pin_fall  = pin_level_r & (pin_sync_r[1] == pin_sync_r[2]) &
                   ~pin_sync_r[2];
  wire edge_mode = pinctl_r[`BIT_EDGE];

  ////////////////////////////////////////////////////////////////////////
  // Local gating of the named peripheral sources
  // The clock monitor counts when either its enable or its forced
  // enable is set; the serial causes share one request line
  wire async_req = |(async_serial_flags &
                    {local_r[`BIT_IDLE_EN], local_r[`BIT_RXF_EN],
                     local_r[`BIT_TXC_EN], local_r[`BIT_TXE_EN]});
  // Edge mode uses the latch, level mode the low level
  wire pin_req   = pinctl_r[`BIT_PIN_EN] &
                   (edge_mode ? edge_latch_r : ~pin_level_r);
  wire cm_fail   = clock_monitor_fail &
                   (local_r[`BIT_CM_EN] | local_r[`BIT_FCM_EN]);
  // Pin request to the core counts only while its mask bit is clear
  wire nmi_req   = ~nmi_level_r & ~x_mask;

  // Maskable request vector, slot index follows vector address.
  // Each named source replaces the raw line of its slot; every other
  // slot passes the pre-gated line, so reserved slots stay usable.
  logic [`NSLOT-1:0] mreq;
  genvar g;
  generate
    for (g = 0; g < `NSLOT; g++) begin : g_slot
      if (g == `SLOT_PIN) begin : g_pin
        // Pin path, already gated by its enable and edge select
        assign mreq[g] = pin_req;
      end else if (g == `SLOT_PAOV) begin : g_paov
        // Accumulator overflow, own local enable
        assign mreq[g] = pulse_acc_overflow_flag &
                         local_r[`BIT_PAOV_EN];
      end else if (g == `SLOT_PAEDGE) begin : g_paedge
        // Accumulator input edge, own local enable
        assign mreq[g] = pulse_acc_edge_flag &
                         local_r[`BIT_PAEDGE_EN];
      end else if (g == `SLOT_SSDONE) begin : g_ssdone
        // Synchronous serial transfer done
        assign mreq[g] = sync_serial_done_flag &
                         local_r[`BIT_SSDONE_EN];
      end else if (g == `SLOT_ASYNC) begin : g_async
        // Four asynchronous serial causes share one slot
        assign mreq[g] = async_req;
      end else if (g == `SLOT_MODU) begin : g_modu
        // Modulus counter underflow
        assign mreq[g] = modulus_underflow_flag &
                         local_r[`BIT_MODU_EN];
      end else if (g == `SLOT_PB) begin : g_pb
        // Second accumulator overflow
        assign mreq[g] = second_pulse_acc_overflow_flag &
                         local_r[`BIT_PB_EN];
      end else begin : g_raw
        // Reserved or plain slot, pre-gated outside this block
        assign mreq[g] = periph_request[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Maskable arbitration
  // Highest slot wins by default, so order descends with address.
  // A plain loop keeps the encoder readable; the last hit overwrites,
  // so the slot with the highest index is the one returned, and an
  // empty request word returns slot zero, which nobody then uses
  function automatic exc_pkg::slot_t top_slot(input logic [`NSLOT-1:0] r);
    exc_pkg::slot_t s;
    s = '0;
    for (int k = 0; k < `NSLOT; k++) begin
      if (r[k])
        s = 6'(k);
    end
    return s;
  endfunction

  // Elevation value is the vector low byte; odd or out of range lifts none.
  // A stale value can never lift a source that is not requesting: the
  // lifted slot must still show its own gated request below.
  wire [5:0]      elev_slot = prio_r[`ELEV_SLOT_HI:`ELEV_SLOT_LO];
  wire            elev_page = prio_r[`BIT_ELEV_PAGE];
  wire            elev_odd  = prio_r[`BIT_ELEV_ODD];
  wire            elev_ok   = elev_page & ~elev_odd & (elev_slot <= `SLOT_MAX);
  // Lifted source still needs its own gated request
  wire            elev_hit  = elev_ok & mreq[elev_slot];
  wire            any_mreq  = |mreq;
  wire            mask_ok   = any_mreq & ~i_mask;
  // Relative order of the rest is untouched: plain encoder still ranks them
  wire [5:0]      win_slot  = elev_hit ? elev_slot : top_slot(mreq);
  // Vector follows the slot, never the priority assignment
  // Slot k sits at byte 80 + 2k of the top page, always word aligned,
  // so a lifted source still fetches its own handler address
  wire [15:0]     mvec      = {`VEC_HI_BYTE, 1'b1, win_slot, 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // Fixed hierarchy over all sources.
  // Resets outrank the traps, the traps outrank the pin request, and
  // any non-maskable source outranks every maskable one, lifted or not
  exc_pkg::win_e win;
  always_comb begin
    if (por_request)
      win = exc_pkg::WIN_RESET;
    else if (cm_fail)
      win = exc_pkg::WIN_CLKMON;
    else if (watchdog_reset)
      win = exc_pkg::WIN_WDOG;
    else if (illegal_opcode_trap)
      win = exc_pkg::WIN_TRAP;
    else if (software_trap_instruction)
      win = exc_pkg::WIN_SWTRAP;
    else if (nmi_req)
      win = exc_pkg::WIN_NMI;
    else if (mask_ok)
      win = exc_pkg::WIN_MASK;
    else
      win = exc_pkg::WIN_NONE;
  end

  // Vector choice, all inside the top 128 bytes
  // Six fixed words on top, the maskable page below them
  logic [15:0] vec_nxt;
  always_comb begin
    case (win)
      exc_pkg::WIN_RESET:  vec_nxt = `VEC_RESET;
      exc_pkg::WIN_CLKMON: vec_nxt = `VEC_CLKMON;
      exc_pkg::WIN_WDOG:   vec_nxt = `VEC_WDOG;
      exc_pkg::WIN_TRAP:   vec_nxt = `VEC_TRAP;
      exc_pkg::WIN_SWTRAP: vec_nxt = `VEC_SWTRAP;
      exc_pkg::WIN_NMI:    vec_nxt = `VEC_NMI_PIN;
      exc_pkg::WIN_MASK:   vec_nxt = mvec;
      default:             vec_nxt = `VEC_RESET;
    endcase
  end

  // Request and class flags for the core; any fixed source, reset
  // included, is reported as non-maskable
  wire req_nxt = (win != exc_pkg::WIN_NONE);
  wire nmi_nxt = req_nxt & (win != exc_pkg::WIN_MASK);

  // Registered answer to the core, one cycle behind the sources
  // Registering costs a cycle but keeps the vector free of glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_r <= 1'b0;
      nmi_r <= 1'b0;
      vec_r <= `VEC_RESET;
    end else begin
      req_r <= req_nxt;
      nmi_r <= nmi_nxt;
      vec_r <= vec_nxt;
    end
  end

  // Outputs straight from the answer flops
  assign exception_request     = req_r;
  assign exception_nonmaskable = nmi_r;
  assign exception_vector      = vec_r;

  ////////////////////////////////////////////////////////////////////////
  // Edge latch: a new fall in the service cycle is kept.
  // Service is recognised only while the pin's own vector is on offer,
  // so acking another source never drops a pending pin edge; leaving
  // edge mode empties the latch so a stale edge is not taken later
  wire pin_served = service_ack & req_r & ~nmi_r &
                    (vec_r == {`VEC_HI_BYTE, 1'b1, `SLOT_PIN, 1'b0});
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      edge_latch_r <= 1'b0;
    else if (edge_mode & pin_fall)
      edge_latch_r <= 1'b1;
    else if (pin_served | ~edge_mode)
      edge_latch_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  // Unused bits are cut on write so a read shows only live fields;
  // the elevation byte only moves while maskable requests are held off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r   <= `MASK_RESET;
      prio_r   <= `PRIO_RESET;
      pinctl_r <= `PINCTL_RESET;
      local_r  <= '0;
      evt_en_r <= '0;
    end else begin
      if (wr_acc & hit_mask)
        mask_r <= pwdata[7:0] & `MASK_RESET;
      if (prio_take)
        prio_r <= pwdata[7:0];
      if (wr_acc & hit_pin)
        pinctl_r <= pwdata[7:0] & `PINCTL_WMASK;
      if (wr_acc & hit_local)
        local_r <= pwdata[`LOCAL_W-1:0];
      if (wr_acc & hit_en)
        evt_en_r <= pwdata[`EVT_W-1:0];
    end
  end

  // Sticky events; a set in the clear cycle wins.
  // Losing an event that arrives while software clears an older one
  // would hide it for good, so the set term is applied after the clear
  wire [`EVT_W-1:0] evt_set = {nmi_req, prio_refd, service_ack & req_r};
  wire [`EVT_W-1:0] evt_clr = (wr_acc & hit_clr) ? pwdata[`EVT_W-1:0] : '0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      evt_stat_r <= '0;
    else
      evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_set;
  end

  // Level interrupt while any enabled event stands; it drops only
  // when software clears the event or removes its enable
  assign irq = |(evt_stat_r & evt_en_r);

  ////////////////////////////////////////////////////////////////////////
  // Read mux; the clear register reads as zero
  // Write-only and unmapped words read as zero, never as stale data
  logic [31:0] rd_mux;
  always_comb begin
    case (1'b1)
      hit_mask:  rd_mux = {24'h0, mask_r};
      hit_prio:  rd_mux = {24'h0, prio_r};
      hit_pin:   rd_mux = {24'h0, pinctl_r};
      hit_local: rd_mux = {21'h0, local_r};
      hit_state: rd_mux = {13'h0, edge_latch_r, nmi_r, req_r, vec_r};
      hit_stat:  rd_mux = {29'h0, evt_stat_r};
      hit_en:    rd_mux = {29'h0, evt_en_r};
      default:   rd_mux = 32'h0;
    endcase
  end

  // Read data from a flop, loaded in the setup cycle of each read.
  // With pready tied high the access edge is also the edge at which the
  // master takes the word, so it must already stand there; the price is
  // that a read shows the state as it was one cycle before that edge.
  // Between reads the word is held, so a slow master sees no change.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      prdata <= 32'h0;
    else if (rd_setup)
      prdata <= rd_mux;
  end

endmodule

/* exc_chk.sv */
// Purpose: Port checks of exception arbitration and vectors
// Assumes: Sources are synchronous levels, outputs one cycle later
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ps
//////////////////////////////////////////////////
module exc_chk (
  input logic        clk,
  input logic        rst,
  input logic        por_request,
  input logic        clock_monitor_fail,
  input logic        watchdog_reset,
  input logic        illegal_opcode_trap,
  input logic        software_trap_instruction,
  input logic        exception_request,
  input logic        exception_nonmaskable,
  input logic [15:0] exception_vector
);
  logic        req;
  logic        nmk;
  logic        hi3;
  logic [15:0] vec;
  // Short aliases; hi3 outranks both traps
  assign req = exception_request;
  assign nmk = exception_nonmaskable;
  assign vec = exception_vector;
  assign hi3 = por_request | clock_monitor_fail | watchdog_reset;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////
  a_vec_top_page: assert property (
    req |-> vec[15:7] == 9'h1FF) else $error("vector outside top page");
  a_vec_word_even: assert property (
    req |-> !vec[0]) else $error("vector not word aligned");
  a_fixed_slots_high: assert property (
    req && nmk |-> vec >= 16'hFFF4) else $error("fixed source below its slots");
  a_mask_slots_low: assert property (
    req && !nmk |-> vec <= 16'hFFF2) else $error("maskable source in fixed slot");
  a_reset_first: assert property (
    por_request |=> req && nmk && vec == 16'hFFFE) else $error("reset not first");
  a_wdog_vector: assert property (
    watchdog_reset && !por_request && !clock_monitor_fail |=> nmk && vec == 16'hFFFA)
    else $error("watchdog vector wrong");
  a_trap_vector: assert property (
    illegal_opcode_trap && !hi3 |=> nmk && vec == 16'hFFF8) else $error("trap vector wrong");
  a_swtrap_order: assert property (
    software_trap_instruction && !hi3 && !illegal_opcode_trap |=> vec == 16'hFFF6)
    else $error("software trap vector wrong");
  c_reset: cover property (por_request ##1 req);
  c_swtrap: cover property (software_trap_instruction ##1 vec == 16'hFFF6);
  c_maskable: cover property (req && !nmk);
endmodule
//////////////////////////////////////////////////
bind exception_priority_vectoring exc_chk chk (.*);

/* core_model.sv */
// Purpose: Core side, acknowledges taken maskable vectors
// Assumes: Ack is one pulse, prompt or after a few cycles
// Notes:   Acks only while the bench allows it
`timescale 1ns/1ps
//////////////////////////////////////////////////
module core_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ack_en,
  input  wire logic slow,
  input  wire logic exception_request,
  input  wire logic exception_nonmaskable,
  output logic      service_ack
);
  logic [1:0] wait_r;
  logic       go;
  // Slow mode waits three cycles; gap after each pulse
  assign go = ack_en & exception_request & !exception_nonmaskable & !service_ack;
  // One pulse clears the pin edge latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 2'h0;
      service_ack <= 1'b0;
    end else begin
      wait_r <= (go && slow && wait_r != 2'h3) ? wait_r + 2'h1 : 2'h0;
      service_ack <= go && (!slow || wait_r == 2'h3);
    end
  end
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for exception arbitration
// Assumes: Zero-wait APB, read word taken at the access edge
// Notes:   Results come back through the state register
`timescale 1ns/1ps
`include "exc_defs.svh"
module tb_top;
  typedef struct {logic [7:0] a; logic [32:0] d; logic [32:0] m; logic e;} note_s;
  localparam logic [32:0] F = 33'h1_FFFF_FFFF;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, ack_en, slow;
  logic nonmaskable_pin_request_n, maskable_pin_n, service_ack, rd_take, err_seen;
  logic exception_request, exception_nonmaskable;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] exception_vector, rvec, ev;
  logic [57:0] periph_request;
  logic [36:0] rv;
  logic [32:0] got;
  logic [4:0]  nm;
  logic [8:0]  fl;
  wire  por_request, clock_monitor_fail, watchdog_reset, illegal_opcode_trap;
  wire  software_trap_instruction, pulse_acc_overflow_flag, pulse_acc_edge_flag;
  wire  sync_serial_done_flag, modulus_underflow_flag, second_pulse_acc_overflow_flag;
  wire  [3:0] async_serial_flags;
  int   n_mismatch, n_checks;
  note_s q[$];
  note_s cur;
  // Grouped sources fan out, bit order as the local enables
  assign {software_trap_instruction, illegal_opcode_trap, watchdog_reset,
          clock_monitor_fail, por_request} = nm;
  assign {second_pulse_acc_overflow_flag, modulus_underflow_flag, async_serial_flags,
          sync_serial_done_flag, pulse_acc_edge_flag, pulse_acc_overflow_flag} = fl;
  exception_priority_vectoring dut (.*);
  core_model core (.*);
  //////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check_rd(input note_s n, input logic [32:0] seen, input logic e);
    n_checks++;
    if ((seen & n.m) !== (n.d & n.m) || e !== n.e) begin
      n_mismatch++;
      $display("mismatch reg %h expected %h %b seen %h %b", n.a, n.d & n.m, n.e, seen & n.m, e);
    end
  endtask
  // Request held until pready is seen high at an edge
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [32:0] x, input logic [32:0] m, input logic e);
    q.push_back('{a, x, m, e});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    rd_take <= 1'b1;
    err_seen <= pslverr;
    got <= {irq, prdata};
    @(posedge clk);
    rd_take <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, a, d, 33'h0, 33'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] m);
    op(1'b0, a, 32'h0, x, m, 1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////
  // Oldest note meets the word and irq taken at the access edge
  always @(posedge clk) begin
    if (rd_take === 1'b1) begin
      cur = q.pop_front();
      check_rd(cur, got, err_seen);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard, far beyond the roughly 330 cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    {rst, nonmaskable_pin_request_n, maskable_pin_n} = 3'h7;
    {psel, penable, pwrite, rd_take, err_seen, ack_en, slow} = 7'h0;
    {paddr, pwdata, periph_request, nm, fl} = '0;
    seed = 32'h0001_044A;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_MASK, 33'h50, F);
    rd(`OFS_PRIO, 33'hF2, F);
    rd(`OFS_PINCTL, 33'h40, F);
    op(1'b0, 8'h20, 32'h0, 33'h0, 33'h0, 1'b1);
    wr(`OFS_LOCAL, 32'h200);
    // Lowest first, so power-on reset comes last
    for (int i = 4; i >= 0; i--) begin
      nm <= 5'h1F << i;
      rd(`OFS_STATE, {17'h3, 16'hFFFE - 16'(2 * i)}, F);
    end
    nm <= 5'h0;
    wr(`OFS_MASK, 32'h10);
    nonmaskable_pin_request_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`OFS_STATE, {17'h3, 16'hFFF4}, F);
    nm <= 5'h10;
    rd(`OFS_STATE, {17'h3, 16'hFFF6}, F);
    nm <= 5'h0;
    wr(`OFS_MASK, 32'h50);
    repeat (6) @(posedge clk);
    rd(`OFS_STATE, 33'h0, 33'h3_0000);
    nonmaskable_pin_request_n <= 1'b1;
    // Random requests sit below every named source
    seed = xs(seed);
    rv = {seed[4:0], seed} | 37'h1;
    slow <= seed[5];
    for (int k = 0; k < 37; k++)
      if (rv[k]) rvec = 16'hFF80 + 16'(2 * k);
    periph_request <= {21'h0, rv};
    wr(`OFS_MASK, 32'h40);
    for (int j = 0; j < 9; j++) begin
      ev = j < 3 ? 16'hFFDC - 16'(2 * j) : (j < 7 ? 16'hFFD6 : 16'hFFCC - 16'(2 * j - 14));
      fl <= 9'h1 << j;
      wr(`OFS_LOCAL, 32'h0);
      rd(`OFS_STATE, {17'h1, rvec}, F);
      wr(`OFS_LOCAL, 32'h1 << j);
      rd(`OFS_STATE, {17'h1, ev}, F);
    end
    wr(`OFS_MASK, 32'h50);
    wr(`OFS_PRIO, 32'hCA);
    wr(`OFS_MASK, 32'h40);
    fl <= 9'h1FF;
    wr(`OFS_LOCAL, 32'h1FF);
    rd(`OFS_STATE, {17'h1, 16'hFFCA}, F);
    fl <= 9'h0FF;
    rd(`OFS_STATE, {17'h1, 16'hFFDC}, F);
    wr(`OFS_PRIO, 32'hDC);
    rd(`OFS_PRIO, 33'hCA, F);
    fl <= 9'h1FF;
    wr(`OFS_MASK, 32'h50);
    rd(`OFS_STATE, 33'h0, 33'h1_0000);
    // Refused-write event drives irq, then masked, then cleared
    wr(`OFS_EVT_EN, 32'h2);
    // Pin request event from the non-maskable scenario still stands
    rd(`OFS_EVT_STAT, 33'h1_0000_0006, F);
    wr(`OFS_EVT_EN, 32'h0);
    rd(`OFS_EVT_STAT, 33'h6, F);
    wr(`OFS_EVT_EN, 32'h2);
    wr(`OFS_EVT_CLR, 32'h7);
    rd(`OFS_EVT_CLR, 33'h0, F);
    // Edge mode holds a short fall until serviced
    fl <= 9'h0;
    wr(`OFS_MASK, 32'h40);
    wr(`OFS_PINCTL, 32'hC0);
    maskable_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    maskable_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`OFS_STATE, {17'h5, 16'hFFF2}, F);
    ack_en <= 1'b1;
    repeat (8) @(posedge clk);
    ack_en <= 1'b0;
    rd(`OFS_STATE, {17'h1, rvec}, F);
    @(posedge clk);
    conclude();
  end
endmodule
